// ### src/vsd_pkg.sv
// How it works
// - Horizontal scaler drops horizontal_decimation of each 64 input pixels; zero keeps all.
// - Vertical scaler drops vertical_decimation of each 64 lines; zero keeps all lines.
// - duplicated_field_opt 1 gives the bottom field a shifted drop pattern.
// - color_convert_select: 00 YUV, 01 RGB888, 10 RGB565, 11 RGB555.
// - error_diffusion_on 1 carries quantization error into the next pixel.
// - Bursts issue only with bus-master enable and video_output_enable both 1.
// - Each field lands in a rectangle: field base, stride, height, width.
// - top_field_only_select 1 writes only the top field.
// - In capture mode each raised capture_request stores one frame or top field.
// - Setting capture_mode freezes live output at the next vertical sync.
// - A capture request waits for vertical sync, then writes two fields, or one with top_field_only_select.
// - Hardware clears capture_request after the last captured field.
// - Clearing capture_mode resumes live output at the next vertical sync once any capture in progress has finished.
// - Word layout follows selector, rgb24_packing and byte_order_select.
// - YUV little: Y1 V0 Y0 U0 high to low; big: V0 Y1 U0 Y0.
// - RGB555 halfword 0,R,G,B, pixel 1 high; big endian swaps bytes.
// - RGB565 halfword R,G6,B, pixel 1 high; big endian swaps bytes.
// - Unpacked RGB888 one word per pixel: little 0RGB, big BGR0.
// - Packed RGB888 puts four pixels in three words, restarting each line.
// - With overlay_mask_enable, pixels whose mask bit is 0 are not written.
// - Mask lines fetched from mask field base plus mask stride, (width+31)>>5 words.
// - Mask word k bit j controls pixel 32k+j.
package vsd_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SCALE = 8'h04;
  localparam logic [7:0] OFS_TOP = 8'h08;
  localparam logic [7:0] OFS_BOT = 8'h0c;
  localparam logic [7:0] OFS_STRIDE = 8'h10;
  localparam logic [7:0] OFS_WIN = 8'h14;
  localparam logic [7:0] OFS_MTOP = 8'h18;
  localparam logic [7:0] OFS_MBOT = 8'h1c;
  localparam logic [7:0] OFS_MSTRIDE = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam int C_VEN = 0;
  localparam int C_TOP = 1;
  localparam int C_CAPM = 2;
  localparam int C_CREQ = 3;
  localparam int C_DUP = 4;
  localparam int C_CSEL = 5;
  localparam int C_ERR = 7;
  localparam int C_PACK = 8;
  localparam int C_LE = 9;
  localparam int C_OVL = 10;
  localparam logic [10:0] CTRL_RST = 11'h200;
  localparam int S_H = 0;
  localparam int S_V = 8;
  localparam int W_W = 0;
  localparam int W_H = 16;
  localparam int ST_OVR = 0;
  localparam logic [6:0] GRP = 7'h40;
  localparam logic [6:0] DUP_OFS = 7'h20;
  localparam logic [10:0] MASK_RND = 11'h01f;
  localparam logic signed [9:0] K_RV = 10'sh167;
  localparam logic signed [9:0] K_GU = 10'sh058;
  localparam logic signed [9:0] K_GV = 10'sh0b7;
  localparam logic signed [9:0] K_BU = 10'sh1c6;
  localparam logic signed [9:0] C_MID = 10'sh080;
  localparam logic [1:0] NF_BOTH = 2'h2;
  localparam logic [1:0] NF_TOP = 2'h1;
  typedef enum logic [1:0] {
    CS_YUV = 2'b00, CS_RGB888 = 2'b01, CS_RGB565 = 2'b10, CS_RGB555 = 2'b11
  } vsd_csel_e;
  typedef enum logic [2:0] {
    CAP_LIVE = 3'b000, CAP_FRZ_WAIT = 3'b001, CAP_FROZEN = 3'b010,
    CAP_GRAB_WAIT = 3'b011, CAP_GRAB = 3'b100, CAP_RES_WAIT = 3'b101
  } vsd_cap_e;
  typedef struct packed {
    logic valid;
    logic hsync;
    logic vsync;
    logic bottom;
    logic [7:0] y;
    logic [7:0] c;
  } vsd_vid_s;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] be;
  } vsd_dma_s;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } vsd_bus_s;
endpackage : vsd_pkg

// ### src/vsd_video_dma.sv
module vsd_video_dma (
  input wire logic ref_clk,
  input wire logic srst,
  input vsd_pkg::vsd_bus_s bus,
  output logic [31:0] rdata,
  input wire logic pci_master_enable,
  input vsd_pkg::vsd_vid_s vid,
  output vsd_pkg::vsd_dma_s dma,
  output logic dma_valid,
  input wire logic dma_ready,
  output logic mask_req_valid,
  output logic [31:0] mask_req_addr,
  input wire logic mask_rsp_valid,
  input wire logic [31:0] mask_rsp_data
);
  import vsd_pkg::*;

  typedef struct packed {
    logic [10:0] ctrl;
    logic [5:0] hdcm, vdcm;
    logic [31:0] top_base, bot_base, stride;
    logic [9:0] width, height;
    logic [31:0] mtop, mbot, mstride;
    logic ovr;
    logic [31:0] rdata;
    vsd_cap_e cap;
    logic [1:0] fcnt;
    logic field_on, line_on;
    logic [6:0] vacc, hacc;
    logic in_par;
    logic [9:0] ln, x;
    logic [31:0] line_addr, next_line, mnext;
    logic [7:0] u, v;
    logic [2:0] er, eg, eb;
    logic [63:0] acc;
    logic [7:0] acc_be;
    logic [3:0] acc_cnt;
    logic [9:0] widx;
    vsd_dma_s dma;
    logic dma_valid;
    logic [5:0] m_idx, m_words;
    logic m_busy, mreq;
    logic [31:0] mreq_addr, mline;
  } vsd_state_s;

  vsd_state_s s_reg;
  vsd_state_s s_next;
  logic [31:0] mask_mem [32];
  logic issue_ok, v_drop, h_drop, wr_pix, pmask, e_valid, keep, six;
  logic [6:0] v_sum, h_sum;
  logic [7:0] cu, cv, r8, g8, b8;
  logic signed [9:0] ud, vd;
  logic [8:0] dr, dg, db;
  logic [31:0] pb, e_data, e_addr;
  logic [3:0] pbe, e_be, tot;
  logic [2:0] pn;
  logic [63:0] cat;
  logic [7:0] cat_be;
  logic [15:0] hw;
  logic [10:0] w_rnd;
  logic [1:0] nf;

  function automatic logic [7:0] sat8(input logic signed [19:0] val);
    logic [7:0] res;
    if (val < 0) res = 8'h00;
    else if (val > 20'sh0ffff) res = 8'hff;
    else res = val[15:8];
    return res;
  endfunction : sat8

  // Result is {quantized[5:0], residual[2:0]}; saturating keeps white from wrapping
  function automatic logic [8:0] diff(input logic [7:0] c, input logic [2:0] e,
                                      input logic g6);
    logic [8:0] t;
    logic [8:0] res;
    t = {1'b0, c} + {6'h00, e};
    if (t[8]) t = 9'h0ff;
    if (g6) res = {t[7:2], 1'b0, t[1:0]};
    else res = {1'b0, t[7:3], t[2:0]};
    return res;
  endfunction : diff

  assign nf = s_reg.ctrl[C_TOP] ? NF_TOP : NF_BOTH;

  always_comb begin
    s_next = s_reg;
    issue_ok = pci_master_enable && s_reg.ctrl[C_VEN];
    e_valid = 1'b0;
    e_data = s_reg.acc[31:0];
    e_be = s_reg.acc_be[3:0];
    e_addr = s_reg.line_addr + {20'h0, s_reg.widx, 2'b00};
    v_sum = s_reg.vacc + {1'b0, s_reg.vdcm};
    v_drop = v_sum >= GRP;
    keep = !v_drop && s_reg.field_on && (s_reg.ln < s_reg.height);
    h_sum = s_reg.hacc + {1'b0, s_reg.hdcm};
    h_drop = h_sum >= GRP;
    wr_pix = 1'b0;
    cu = s_reg.in_par ? s_reg.u : vid.c;
    cv = s_reg.in_par ? vid.c : s_reg.v;
    ud = $signed({2'b00, cu}) - C_MID;
    vd = $signed({2'b00, cv}) - C_MID;
    r8 = sat8($signed({4'h0, vid.y, 8'h00}) + K_RV * vd);
    g8 = sat8($signed({4'h0, vid.y, 8'h00}) - K_GU * ud - K_GV * vd);
    b8 = sat8($signed({4'h0, vid.y, 8'h00}) + K_BU * ud);
    six = vsd_csel_e'(s_reg.ctrl[C_CSEL+:2]) == CS_RGB565;
    dr = diff(r8, s_reg.er, 1'b0);
    dg = diff(g8, s_reg.eg, six);
    db = diff(b8, s_reg.eb, 1'b0);
    hw = 16'h0000;
    pb = 32'h0;
    pn = 3'h2;
    case (vsd_csel_e'(s_reg.ctrl[C_CSEL+:2]))
      CS_YUV: hw = {vid.y, s_reg.x[0] ? cv : cu};
      CS_RGB565: hw = {dr[7:3], dg[8:3], db[7:3]};
      CS_RGB555: hw = {1'b0, dr[7:3], dg[7:3], db[7:3]};
      default: begin
        if (s_reg.ctrl[C_PACK]) begin
          pb = {8'h00, r8, g8, b8};
          pn = 3'h3;
        end else begin
          pb = s_reg.ctrl[C_LE] ? {8'h00, r8, g8, b8} : {b8, g8, r8, 8'h00};
          pn = 3'h4;
        end
      end
    endcase
    if (pn == 3'h2) begin
      pb = s_reg.ctrl[C_LE] ? {16'h0, hw} : {16'h0, hw[7:0], hw[15:8]};
    end
    pmask = !s_reg.ctrl[C_OVL] || mask_mem[s_reg.x[9:5]][s_reg.x[4:0]];
    pbe = {4{pmask}} & (pn == 3'h4 ? 4'hf : (pn == 3'h3 ? 4'h7 : 4'h3));
    // Byte stream lets packed 24-bit words straddle pixels without a mux per phase
    cat = s_reg.acc | ({32'h0, pb} << {s_reg.acc_cnt[2:0], 3'b000});
    cat_be = s_reg.acc_be | ({4'h0, pbe} << s_reg.acc_cnt[2:0]);
    tot = s_reg.acc_cnt + {1'b0, pn};
    w_rnd = {1'b0, s_reg.width} + MASK_RND;

    // Capture sequencing
    case (s_reg.cap)
      CAP_LIVE: begin
        if (s_reg.ctrl[C_CAPM]) s_next.cap = CAP_FRZ_WAIT;
      end
      CAP_FRZ_WAIT: begin
        if (!s_reg.ctrl[C_CAPM]) s_next.cap = CAP_LIVE;
        else if (vid.vsync) s_next.cap = CAP_FROZEN;
      end
      CAP_FROZEN: begin
        if (!s_reg.ctrl[C_CAPM]) s_next.cap = CAP_RES_WAIT;
        else if (s_reg.ctrl[C_CREQ]) s_next.cap = CAP_GRAB_WAIT;
      end
      CAP_GRAB_WAIT: begin
        if (vid.vsync) begin
          s_next.cap = CAP_GRAB;
          s_next.fcnt = 2'h0;
        end
      end
      CAP_GRAB: begin
        if (vid.vsync && s_reg.field_on) begin
          s_next.fcnt = s_reg.fcnt + 2'h1;
          if (s_reg.fcnt + 2'h1 == nf) begin
            s_next.cap = CAP_FROZEN;
            s_next.ctrl[C_CREQ] = 1'b0;
          end
        end
      end
      CAP_RES_WAIT: begin
        if (vid.vsync) s_next.cap = CAP_LIVE;
      end
      default: s_next.cap = CAP_LIVE;
    endcase

    // Mask fetch: one read outstanding; the line must arrive during blanking
    s_next.mreq = 1'b0;
    if (mask_rsp_valid && s_reg.m_busy) begin
      s_next.m_idx = s_reg.m_idx + 6'h01;
      if (s_reg.m_idx + 6'h01 == s_reg.m_words) begin
        s_next.m_busy = 1'b0;
      end else begin
        s_next.mreq = 1'b1;
        s_next.mreq_addr = s_reg.mline + {24'h0, s_reg.m_idx + 6'h01, 2'b00};
      end
    end

    if (vid.vsync || vid.hsync) begin
      // Trailing partial word of the previous line
      e_valid = s_reg.acc_cnt != 4'h0;
      s_next.acc = 64'h0;
      s_next.acc_be = 8'h00;
      s_next.acc_cnt = 4'h0;
      s_next.widx = 10'h000;
      s_next.hacc = 7'h00;
      s_next.x = 10'h000;
      s_next.in_par = 1'b0;
      s_next.er = 3'h0;
      s_next.eg = 3'h0;
      s_next.eb = 3'h0;
    end
    if (vid.vsync) begin
      s_next.vacc = (s_reg.ctrl[C_DUP] && vid.bottom) ? DUP_OFS : 7'h00;
      s_next.ln = 10'h000;
      s_next.line_on = 1'b0;
      s_next.next_line = vid.bottom ? s_reg.bot_base : s_reg.top_base;
      s_next.mnext = vid.bottom ? s_reg.mbot : s_reg.mtop;
      s_next.field_on = (s_next.cap == CAP_LIVE || s_next.cap == CAP_FRZ_WAIT ||
                         s_next.cap == CAP_GRAB) && !(s_reg.ctrl[C_TOP] && vid.bottom);
    end else if (vid.hsync) begin
      s_next.vacc = v_drop ? v_sum - GRP : v_sum;
      s_next.line_on = keep;
      if (keep) begin
        s_next.ln = s_reg.ln + 10'h001;
        s_next.line_addr = s_reg.next_line;
        s_next.next_line = s_reg.next_line + s_reg.stride;
        s_next.mline = s_reg.mnext;
        s_next.mnext = s_reg.mnext + s_reg.mstride;
        if (s_reg.ctrl[C_OVL] && s_reg.width != 10'h000) begin
          s_next.m_busy = 1'b1;
          s_next.m_idx = 6'h00;
          s_next.m_words = w_rnd[10:5];
          s_next.mreq = 1'b1;
          s_next.mreq_addr = s_reg.mnext;
        end
      end
    end else if (vid.valid) begin
      s_next.in_par = ~s_reg.in_par;
      if (!s_reg.in_par) s_next.u = vid.c;
      else s_next.v = vid.c;
      s_next.hacc = h_drop ? h_sum - GRP : h_sum;
      if (!h_drop && s_reg.x < s_reg.width) begin
        s_next.x = s_reg.x + 10'h001;
        wr_pix = s_reg.line_on;
      end
    end

    if (wr_pix) begin
      if (s_reg.ctrl[C_ERR] && pn == 3'h2 && s_reg.ctrl[C_CSEL+:2] != 2'b00) begin
        s_next.er = dr[2:0];
        s_next.eg = dg[2:0];
        s_next.eb = db[2:0];
      end
      if (tot >= 4'h4) begin
        e_valid = 1'b1;
        e_data = cat[31:0];
        e_be = cat_be[3:0];
        s_next.acc = {32'h0, cat[63:32]};
        s_next.acc_be = {4'h0, cat_be[7:4]};
        s_next.acc_cnt = tot - 4'h4;
        s_next.widx = s_reg.widx + 10'h001;
      end else begin
        s_next.acc = cat;
        s_next.acc_be = cat_be;
        s_next.acc_cnt = tot;
      end
    end

    // Register writes take effect at once; the host keeps them steady while live
    if (bus.wr) begin
      case (bus.addr)
        OFS_CTRL: s_next.ctrl = bus.wdata[10:0];
        OFS_SCALE: begin
          s_next.hdcm = bus.wdata[S_H+:6];
          s_next.vdcm = bus.wdata[S_V+:6];
        end
        OFS_TOP: s_next.top_base = bus.wdata;
        OFS_BOT: s_next.bot_base = bus.wdata;
        OFS_STRIDE: s_next.stride = bus.wdata;
        OFS_WIN: begin
          s_next.width = bus.wdata[W_W+:10];
          s_next.height = bus.wdata[W_H+:10];
        end
        OFS_MTOP: s_next.mtop = bus.wdata;
        OFS_MBOT: s_next.mbot = bus.wdata;
        OFS_MSTRIDE: s_next.mstride = bus.wdata;
        OFS_STATUS: begin
          if (bus.wdata[ST_OVR]) s_next.ovr = 1'b0;
        end
        default: ;
      endcase
    end

    s_next.rdata = 32'h0;
    if (bus.rd) begin
      case (bus.addr)
        OFS_CTRL: s_next.rdata = {21'h0, s_reg.ctrl};
        OFS_SCALE: s_next.rdata = {18'h0, s_reg.vdcm, 2'b00, s_reg.hdcm};
        OFS_TOP: s_next.rdata = s_reg.top_base;
        OFS_BOT: s_next.rdata = s_reg.bot_base;
        OFS_STRIDE: s_next.rdata = s_reg.stride;
        OFS_WIN: s_next.rdata = {6'h0, s_reg.height, 6'h0, s_reg.width};
        OFS_MTOP: s_next.rdata = s_reg.mtop;
        OFS_MBOT: s_next.rdata = s_reg.mbot;
        OFS_MSTRIDE: s_next.rdata = s_reg.mstride;
        OFS_STATUS: s_next.rdata = {28'h0, s_reg.cap, s_reg.ovr};
        default: s_next.rdata = 32'h0;
      endcase
    end

    // No buffer: a word arriving while one waits is lost and flagged
    if (s_reg.dma_valid && dma_ready) s_next.dma_valid = 1'b0;
    if (e_valid && e_be != 4'h0 && issue_ok) begin
      if (s_reg.dma_valid && !dma_ready) begin
        s_next.ovr = 1'b1;
      end else begin
        s_next.dma_valid = 1'b1;
        s_next.dma.addr = e_addr;
        s_next.dma.data = e_data;
        s_next.dma.be = e_be;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RST;
      s_reg.cap <= CAP_LIVE;
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (mask_rsp_valid && s_reg.m_busy) begin
      mask_mem[s_reg.m_idx[4:0]] <= mask_rsp_data;
    end
  end

  assign rdata = s_reg.rdata;
  assign dma = s_reg.dma;
  assign dma_valid = s_reg.dma_valid;
  assign mask_req_valid = s_reg.mreq;
  assign mask_req_addr = s_reg.mreq_addr;

  // Helper for the group check: pixels seen and dropped in the current group
  logic [5:0] hg_cnt;
  logic [6:0] hg_drops;
  always_ff @(posedge ref_clk) begin
    if (srst || vid.hsync) begin
      hg_cnt <= 6'h00;
      hg_drops <= 7'h00;
    end else if (vid.valid && !vid.vsync) begin
      hg_cnt <= hg_cnt + 6'h01;
      hg_drops <= (hg_cnt == 6'h3f) ? 7'h00 : hg_drops + {6'h00, h_drop};
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // The vsync that ends the wait comes many cycles after the host clears the mode
  sequence s_res_arm;
    s_reg.cap == CAP_RES_WAIT && vid.vsync;
  endsequence
  sequence s_grab_arm;
    s_reg.cap == CAP_GRAB_WAIT && vid.vsync;
  endsequence
  property p_hgroup;
    vid.valid && !vid.hsync && !vid.vsync && hg_cnt == 6'h3f
      |-> hg_drops + {6'h00, h_drop} == {1'b0, s_reg.hdcm};
  endproperty
  a_hgroup: assert property (p_hgroup) else $error("wrong drop count in group");
  property p_vzero;
    vid.hsync && !vid.vsync && s_reg.vdcm == 6'h00 && s_reg.field_on &&
      s_reg.ln < s_reg.height |=> s_reg.line_on;
  endproperty
  a_vzero: assert property (p_vzero) else $error("line dropped with no decimation");
  property p_issue_gate;
    !(pci_master_enable && s_reg.ctrl[C_VEN]) |=> !$rose(dma_valid);
  endproperty
  a_issue_gate: assert property (p_issue_gate) else $error("burst while disabled");
  property p_top_only;
    vid.vsync && vid.bottom && s_reg.ctrl[C_TOP] |=> !s_reg.field_on;
  endproperty
  a_top_only: assert property (p_top_only) else $error("bottom field written");
  property p_grab_req;
    s_reg.cap == CAP_FROZEN && s_reg.ctrl[C_CAPM] && s_reg.ctrl[C_CREQ]
      |=> s_reg.cap == CAP_GRAB_WAIT;
  endproperty
  a_grab_req: assert property (p_grab_req) else $error("capture request ignored");
  property p_freeze;
    s_reg.cap == CAP_FRZ_WAIT && vid.vsync && s_reg.ctrl[C_CAPM] |=> s_reg.cap == CAP_FROZEN;
  endproperty
  a_freeze: assert property (p_freeze) else $error("no freeze at vsync");
  property p_grab_start;
    s_grab_arm |=> s_reg.cap == CAP_GRAB && s_reg.fcnt == 2'h0 ##1 s_reg.cap == CAP_GRAB;
  endproperty
  a_grab_start: assert property (p_grab_start) else $error("grab not started");
  property p_grab_clear;
    s_reg.cap == CAP_GRAB && vid.vsync && s_reg.field_on && s_reg.fcnt + 2'h1 == nf &&
      !bus.wr |=> !s_reg.ctrl[C_CREQ] && s_reg.cap == CAP_FROZEN;
  endproperty
  a_grab_clear: assert property (p_grab_clear) else $error("request not cleared");
  property p_resume;
    s_res_arm |=> s_reg.cap == CAP_LIVE;
  endproperty
  a_resume: assert property (p_resume) else $error("live output not resumed");
  property p_masked;
    $rose(dma_valid) |-> dma.be != 4'h0;
  endproperty
  a_masked: assert property (p_masked) else $error("fully masked word written");
endmodule : vsd_video_dma

// ### tb/vsd_mem_model.sv
module vsd_mem_model (
  input wire logic ref_clk,
  input wire logic srst,
  input vsd_pkg::vsd_dma_s dma,
  input wire logic dma_valid,
  output logic dma_ready,
  input wire logic mask_req_valid,
  input wire logic [31:0] mask_req_addr,
  output logic mask_rsp_valid,
  output logic [31:0] mask_rsp_data,
  input wire logic slow,
  input wire logic [31:0] mask_word
);
  timeunit 1ns;
  timeprecision 1ps;
  import vsd_pkg::*;
  vsd_dma_s wq[$];
  logic [31:0] mq[$];
  logic [1:0] cnt;
  int lat;
  always @(posedge ref_clk) begin
    cnt <= cnt + 2'h1;
    mask_rsp_valid <= 1'b0;
    // Idle data line keeps changing so a stale answer never looks valid
    mask_rsp_data <= ~mask_rsp_data;
    if (srst) begin
      cnt <= 2'h0;
      dma_ready <= 1'b0;
      mask_rsp_data <= '0;
      lat <= 0;
    end else begin
      // Slow memory accepts one write in four cycles
      dma_ready <= !slow || cnt == 2'h3;
      if (dma_valid && dma_ready) wq.push_back(dma);
      if (mask_req_valid) begin
        mq.push_back(mask_req_addr);
        lat <= slow ? 3 : 1;
      end else if (lat > 1) begin
        lat <= lat - 1;
      end else if (lat == 1) begin
        lat <= 0;
        mask_rsp_valid <= 1'b1;
        mask_rsp_data <= mask_word;
      end
    end
  end
endmodule : vsd_mem_model

// ### tb/tb_video_scale_format_dma.sv
module tb_video_scale_format_dma;
  timeunit 1ns;
  timeprecision 1ps;
  import vsd_pkg::*;
  localparam logic [31:0] TB = 32'h0000_1000;
  localparam logic [31:0] BB = 32'h0000_2000;
  localparam logic [31:0] SD = 32'h0000_0100;
  localparam logic [31:0] MB = 32'h0000_3000;
  localparam logic [31:0] MS = 32'h0000_0040;
  localparam logic [31:0] W0 = 32'h1180_1080;
  localparam logic [31:0] W1 = 32'h1380_1280;
  localparam logic [10:0] LE = 11'h1 << C_LE;
  localparam logic [10:0] PK = 11'h1 << C_PACK;
  localparam logic [10:0] OV = 11'h1 << C_OVL;
  localparam logic [10:0] TP = 11'h1 << C_TOP;
  localparam logic [10:0] CM = 11'h1 << C_CAPM;
  localparam logic [10:0] CR = 11'h1 << C_CREQ;
  localparam logic [10:0] DP = 11'h1 << C_DUP;
  localparam logic [10:0] ER = 11'h1 << C_ERR;
  localparam logic [10:0] R8 = 11'(CS_RGB888) << C_CSEL;
  localparam logic [10:0] R6 = 11'(CS_RGB565) << C_CSEL;
  localparam logic [10:0] R5 = 11'(CS_RGB555) << C_CSEL;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  vsd_bus_s bus = '0;
  vsd_vid_s vid = '0;
  logic pci_master_enable = 1'b1;
  logic slow = 1'b0;
  logic [31:0] mask_word = '0;
  logic [31:0] rdata;
  logic [31:0] mask_req_addr;
  logic [31:0] mask_rsp_data;
  vsd_dma_s dma;
  logic dma_valid;
  logic dma_ready;
  logic mask_req_valid;
  logic mask_rsp_valid;
  int mismatches = 0;
  int num_checks = 0;
  int pg = 0;
  logic [7:0] u_val = 8'h11;
  logic [7:0] v_val = 8'h22;
  logic [31:0] d;

  always #10 ref_clk = ~ref_clk;

  vsd_video_dma dut_u (.ref_clk(ref_clk), .srst(srst), .bus(bus), .rdata(rdata),
    .pci_master_enable(pci_master_enable), .vid(vid), .dma(dma), .dma_valid(dma_valid),
    .dma_ready(dma_ready), .mask_req_valid(mask_req_valid), .mask_req_addr(mask_req_addr),
    .mask_rsp_valid(mask_rsp_valid), .mask_rsp_data(mask_rsp_data));
  vsd_mem_model mem_u (.ref_clk(ref_clk), .srst(srst), .dma(dma), .dma_valid(dma_valid),
    .dma_ready(dma_ready), .mask_req_valid(mask_req_valid), .mask_req_addr(mask_req_addr),
    .mask_rsp_valid(mask_rsp_valid), .mask_rsp_data(mask_rsp_data), .slow(slow),
    .mask_word(mask_word));

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus <= '0;
    #1 v = rdata;
  endtask : rd
  task automatic ctl(input logic [10:0] c);
    wr(OFS_CTRL, {21'h0, c | 11'h1});
  endtask : ctl
  // k is {vsync, hsync, bottom}; all zero gives a pixel
  task automatic vin(input logic [2:0] k, input logic [7:0] y, input logic [7:0] c);
    @(posedge ref_clk);
    vid <= '{valid: k[2:1] == 2'b00, hsync: k[1], vsync: k[2], bottom: k[0], y: y, c: c};
  endtask : vin
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      vid <= '0;
    end
  endtask : idle
  // Gap after hsync leaves room for the mask fetch
  task automatic line(input int n, input logic [7:0] y0, input int g);
    vin(3'b010, 8'h0, 8'h0);
    idle(g);
    for (int i = 0; i < n; i++) begin
      vin(3'b000, y0 + 8'(i), i[0] ? v_val : u_val);
      idle(pg);
    end
    idle(6);
  endtask : line
  task automatic fl(input logic [2:0] k);
    vin(k, 8'h0, 8'h0);
    line(4, 8'h10, 0);
  endtask : fl
  task automatic popw(input logic [31:0] a, input logic [31:0] v, input logic [3:0] be);
    vsd_dma_s w;
    w = mem_u.wq.size() > 0 ? mem_u.wq.pop_front() : '0;
    chk(w.addr, a);
    chk(w.data, v);
    chk({28'h0, w.be}, {28'h0, be});
  endtask : popw
  task automatic w2(input logic [31:0] a);
    popw(a, W0, 4'hf);
    popw(a + 32'h4, W1, 4'hf);
  endtask : w2
  task automatic nwords(input int n);
    chk(32'(mem_u.wq.size()), 32'(n));
    mem_u.wq.delete();
  endtask : nwords
  task automatic st(input logic [2:0] e);
    rd(OFS_STATUS, d);
    chk({29'h0, d[3:1]}, {29'h0, e});
  endtask : st
  task automatic fmt(input logic [10:0] c, input logic [7:0] y0, input int n, input int nw,
      input logic [31:0] e0, input logic [31:0] e1, input logic [31:0] e2);
    ctl(c);
    vin(3'b100, 8'h0, 8'h0);
    line(n, y0, 0);
    popw(TB, e0, 4'hf);
    popw(TB + 32'h4, e1, 4'hf);
    if (nw > 2) popw(TB + 32'h8, e2, 4'hf);
    nwords(0);
  endtask : fmt

  task automatic t_regs();
    rd(OFS_CTRL, d);
    chk(d, 32'h200);
    rd(8'hfc, d);
    chk(d, 32'h0);
    wr(OFS_SCALE, 32'h3f3f);
    rd(OFS_SCALE, d);
    chk(d, 32'h3f3f);
    wr(OFS_SCALE, 32'h0);
    wr(OFS_TOP, TB);
    wr(OFS_BOT, BB);
    wr(OFS_STRIDE, SD);
    wr(OFS_WIN, 32'h0040_0040);
    wr(OFS_MTOP, MB);
    wr(OFS_MBOT, 32'h4000);
    wr(OFS_MSTRIDE, MS);
  endtask : t_regs
  task automatic t_fmt();
    fmt(LE, 8'h10, 4, 2, 32'h1122_1011, 32'h1322_1211, 0);
    fmt(0, 8'h10, 4, 2, 32'h2211_1110, 32'h2213_1112, 0);
    slow <= 1'b1;
    pg = 3;
    fmt(LE, 8'h10, 4, 2, 32'h1122_1011, 32'h1322_1211, 0);
    slow <= 1'b0;
    pg = 0;
    u_val <= 8'h80;
    v_val <= 8'h80;
    line(2, 8'h0, 0);
    mem_u.wq.delete();
    fmt(LE | R8, 8'h10, 2, 2, 32'h0010_1010, 32'h0011_1111, 0);
    fmt(R8, 8'h10, 2, 2, 32'h1010_1000, 32'h1111_1100, 0);
    fmt(R8 | PK, 8'h10, 4, 3, 32'h1110_1010, 32'h1212_1111, 32'h1313_1312);
    fmt(LE | R6, 8'h10, 4, 2, 32'h1082_1082, 32'h1082_1082, 0);
    fmt(R6, 8'h10, 4, 2, 32'h8210_8210, 32'h8210_8210, 0);
    fmt(LE | R5, 8'h10, 4, 2, 32'h0842_0842, 32'h0842_0842, 0);
    fmt(R5, 8'h10, 4, 2, 32'h4208_4208, 32'h4208_4208, 0);
    fmt(LE | R6, 8'h06, 4, 2, 32'h0020_0020, 32'h0841_0841, 0);
    fmt(LE | R6 | ER, 8'h06, 4, 2, 32'h0841_0020, 32'h0841_0841, 0);
  endtask : t_fmt
  task automatic t_en();
    ctl(LE);
    pci_master_enable <= 1'b0;
    fl(3'b100);
    nwords(0);
    pci_master_enable <= 1'b1;
    wr(OFS_CTRL, 32'h200);
    fl(3'b100);
    nwords(0);
    // A word every two cycles against one accept in four must overflow the single slot
    slow <= 1'b1;
    ctl(LE);
    vin(3'b100, 8'h0, 8'h0);
    line(8, 8'h10, 0);
    rd(OFS_STATUS, d);
    chk({31'h0, d[ST_OVR]}, 32'h1);
    wr(OFS_STATUS, 32'h1);
    rd(OFS_STATUS, d);
    chk({31'h0, d[ST_OVR]}, 32'h0);
    slow <= 1'b0;
    mem_u.wq.delete();
  endtask : t_en
  task automatic t_scale();
    int hd[3] = '{0, 32, 63};
    int hw[3] = '{32, 16, 1};
    ctl(LE);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_SCALE, 32'(hd[i]));
      vin(3'b100, 8'h0, 8'h0);
      line(64, 8'h0, 0);
      vin(3'b010, 8'h0, 8'h0);
      idle(6);
      if (i == 1) chk(32'(mem_u.wq[0].data[31:24] - mem_u.wq[0].data[15:8]), 32'h2);
      nwords(hw[i]);
    end
    for (int i = 1; i < 3; i++) begin
      wr(OFS_SCALE, 32'(hd[i]) << S_V);
      vin(3'b100, 8'h0, 8'h0);
      repeat (64) line(2, 8'h10, 0);
      nwords(64 - hd[i]);
    end
  endtask : t_scale
  task automatic t_dup();
    logic [7:0] ya[2];
    // Half decimation: the shifted pattern moves the first kept line down by one
    wr(OFS_SCALE, 32'h0000_2000);
    for (int i = 0; i < 2; i++) begin
      ctl(i == 1 ? LE | DP : LE);
      vin(3'b101, 8'h0, 8'h0);
      for (int l = 0; l < 4; l++) line(2, 8'(l * 16), 0);
      ya[i] = mem_u.wq[0].data[15:8];
      mem_u.wq.delete();
    end
    chk({16'h0, ya[0], ya[1]}, 32'h0000_0010);
    wr(OFS_SCALE, 32'h0);
  endtask : t_dup
  task automatic t_rect();
    ctl(LE);
    wr(OFS_WIN, 32'h0002_0002);
    vin(3'b100, 8'h0, 8'h0);
    repeat (3) line(4, 8'h10, 0);
    popw(TB, W0, 4'hf);
    popw(TB + SD, W0, 4'hf);
    nwords(0);
    fl(3'b101);
    popw(BB, W0, 4'hf);
    nwords(0);
    ctl(LE | TP);
    fl(3'b101);
    nwords(0);
    fl(3'b100);
    popw(TB, W0, 4'hf);
    nwords(0);
  endtask : t_rect
  task automatic t_ovl();
    ctl(LE | OV);
    wr(OFS_WIN, 32'h0040_0004);
    mask_word <= 32'h5;
    vin(3'b100, 8'h0, 8'h0);
    line(4, 8'h10, 8);
    line(4, 8'h10, 8);
    chk(32'(mem_u.mq.size()), 32'h2);
    chk(mem_u.mq[0], MB);
    chk(mem_u.mq[1], MB + MS);
    mem_u.mq.delete();
    for (int l = 0; l < 2; l++) begin
      popw(TB + 32'(l) * SD, W0, 4'h3);
      popw(TB + 32'(l) * SD + 32'h4, W1, 4'h3);
    end
    nwords(0);
    wr(OFS_WIN, 32'h0040_0040);
  endtask : t_ovl
  task automatic t_cap();
    ctl(LE | CM);
    st(3'h1);
    fl(3'b100);
    st(3'h2);
    nwords(0);
    wr(OFS_TOP, 32'h5000);
    ctl(LE | CM | CR);
    st(3'h3);
    line(4, 8'h10, 0);
    nwords(0);
    fl(3'b100);
    w2(32'h5000);
    fl(3'b101);
    w2(BB);
    vin(3'b100, 8'h0, 8'h0);
    idle(2);
    rd(OFS_CTRL, d);
    chk({31'h0, d[C_CREQ]}, 32'h0);
    st(3'h2);
    fl(3'b100);
    nwords(0);
    wr(OFS_TOP, TB);
    ctl(LE);
    st(3'h5);
    line(4, 8'h10, 0);
    nwords(0);
    fl(3'b100);
    w2(TB);
    st(3'h0);
  endtask : t_cap

  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    t_regs();
    t_fmt();
    t_en();
    t_scale();
    t_dup();
    t_rect();
    t_ovl();
    t_cap();
    final_report();
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    final_report();
  end
endmodule : tb_video_scale_format_dma
